// *** hw/usbis_core.sv ***
// Interrupt classification, endpoint CRC handling and host pipe mask/status logic
`timescale 1ns/1ps
module usbis_core #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic [usbis_pkg::GS_WIDTH-1:0] global_event,
  input wire logic frame_number_crc_error,
  input wire logic [usbis_pkg::ES_WIDTH-1:0] endpoint_event,
  input wire logic crc_error_seen,
  input wire logic [1:0] data_sequence_field,
  input wire logic [7:0] pipe_event,
  input wire logic pipe_configured,
  input wire logic pipe_request_want,
  output logic pipe_request,
  output logic data_toggle,
  output logic bank_store,
  output logic endpoint_irq,
  output logic pipe_irq,
  output logic irq
);
  initial
  begin
    if (ADDR_W < 12)
      $error("ADDR_W must be at least 12");
  end

  typedef struct packed {
    logic [31:0] rdata;
    logic [31:0] pipe_mask;
    logic [7:0] pipe_stat;
    logic [1:0] pipe_type;
    logic [usbis_pkg::ES_WIDTH-1:0] ep_stat;
    logic [usbis_pkg::ES_WIDTH-1:0] ep_mask;
    logic [1:0] ep_type;
    logic ep_dir_out;
    logic [usbis_pkg::GS_WIDTH-1:0] gl_stat;
    logic [usbis_pkg::GS_WIDTH-1:0] gl_mask;
    logic pipe_request;
    logic data_toggle;
    logic bank_store;
    logic endpoint_irq;
    logic pipe_irq;
    logic irq;
  } usbis_state_s;

  usbis_state_s st_reg;
  usbis_state_s st_next;
  logic [31:0] rd_mux;
  logic [usbis_pkg::ES_WIDTH-1:0] ep_set;
  logic [usbis_pkg::GS_WIDTH-1:0] gl_set;
  logic iso_out;
  logic ctl_bulk;
  logic wr_set;
  logic wr_clr;
  logic [31:0] set_clr_mask;

  // ==========================================================================
  // Set/clear reach the halt bit as well
  // A direct mask write keeps halt as it is, so set/clear are the only software
  // path to freeze or release a pipe.
  assign set_clr_mask = usbis_pkg::PM_WMASK | (32'h0000_0001 << usbis_pkg::PM_HALT);

  // ==========================================================================
  // Event classification
  always_comb
  begin
    iso_out = (st_reg.ep_type == usbis_pkg::EP_TYPE_ISO) && st_reg.ep_dir_out;
    ep_set = endpoint_event;
    ep_set[usbis_pkg::ES_CRC_ERR] = crc_error_seen && iso_out;
    // Corrupted OUT data still counts as received
    ep_set[usbis_pkg::ES_OUT_RX] = endpoint_event[usbis_pkg::ES_OUT_RX] || ep_set[usbis_pkg::ES_CRC_ERR];
    ep_set[usbis_pkg::ES_MDATA] = iso_out && ep_set[usbis_pkg::ES_OUT_RX]
      && (data_sequence_field == usbis_pkg::DSEQ_MDATA);
    ep_set[usbis_pkg::ES_DATAX] = iso_out && ep_set[usbis_pkg::ES_OUT_RX]
      && (data_sequence_field == usbis_pkg::DSEQ_DATAX);
    gl_set = global_event;
    // Frame starts with a frame-number CRC error move to the exception bit
    gl_set[usbis_pkg::GS_SOF] = global_event[usbis_pkg::GS_SOF] && !frame_number_crc_error;
    gl_set[usbis_pkg::GS_MICRO_FRAME_START_FLAG] = global_event[usbis_pkg::GS_MICRO_FRAME_START_FLAG] && !frame_number_crc_error;
    gl_set[usbis_pkg::GS_FRAME_EXC] = (global_event[usbis_pkg::GS_SOF]
      || global_event[usbis_pkg::GS_MICRO_FRAME_START_FLAG]) && frame_number_crc_error;
    gl_set[usbis_pkg::GS_ENDPOINT] = global_event[usbis_pkg::GS_ENDPOINT] || st_reg.endpoint_irq;
  end

  // ==========================================================================
  // Register read mux
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (addr[11:0])
      usbis_pkg::OFF_PIPE_MASK: rd_mux = st_reg.pipe_mask;
      usbis_pkg::OFF_PIPE_STAT: rd_mux = {24'h00_0000, st_reg.pipe_stat};
      usbis_pkg::OFF_PIPE_CFG: rd_mux = {30'h0000_0000, st_reg.pipe_type};
      usbis_pkg::OFF_EP_STAT: rd_mux = {20'h0_0000, st_reg.ep_stat};
      usbis_pkg::OFF_EP_MASK: rd_mux = {20'h0_0000, st_reg.ep_mask};
      usbis_pkg::OFF_EP_CFG: rd_mux = {29'h0000_0000, st_reg.ep_dir_out, st_reg.ep_type};
      usbis_pkg::OFF_GLB_STAT: rd_mux = {22'h00_0000, st_reg.gl_stat};
      usbis_pkg::OFF_GLB_MASK: rd_mux = {22'h00_0000, st_reg.gl_mask};
      // Class view: which status bits are exceptions
      usbis_pkg::OFF_GLB_CLASS: rd_mux = {6'h00, 10'h200, 4'h0, usbis_pkg::ES_EXCEPTION};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    ctl_bulk = (st_reg.pipe_type == usbis_pkg::PT_CONTROL)
      || (st_reg.pipe_type == usbis_pkg::PT_BULK);
    wr_set = wr_stb && (addr[11:0] == usbis_pkg::OFF_PIPE_SET) && ctl_bulk;
    wr_clr = wr_stb && (addr[11:0] == usbis_pkg::OFF_PIPE_CLR) && ctl_bulk;
    st_next.rdata = rd_stb ? rd_mux : 32'h0000_0000;
    // Toggle-reset completes in one cycle, so the status is a one-cycle mark
    st_next.pipe_mask[usbis_pkg::PM_TOGGLE_RESET] = 1'b0;
    if (wr_stb && (addr[11:0] == usbis_pkg::OFF_PIPE_MASK) && ctl_bulk)
      st_next.pipe_mask = (wdata & usbis_pkg::PM_WMASK) | (st_reg.pipe_mask & 32'h0002_0000);
    if (wr_set)
      st_next.pipe_mask = st_reg.pipe_mask | (wdata & set_clr_mask);
    // Halt-clear only releases the pipe; a live hardware cause sets it again below
    if (wr_clr)
      st_next.pipe_mask = st_reg.pipe_mask & ~(wdata & set_clr_mask);
    if (wr_set && wdata[usbis_pkg::PM_TOGGLE_RESET])
    begin
      st_next.pipe_mask[usbis_pkg::PM_TOGGLE_RESET] = 1'b1;
      st_next.data_toggle = 1'b0;
    end
    else if (st_reg.pipe_request)
      st_next.data_toggle = !st_reg.data_toggle;
    // Hardware halt causes win over a same-cycle clear
    if (!pipe_configured || pipe_event[usbis_pkg::PE_STALL] || pipe_event[usbis_pkg::PE_PIPE_ERR])
      st_next.pipe_mask[usbis_pkg::PM_HALT] = 1'b1;
    if (wr_stb && (addr[11:0] == usbis_pkg::OFF_PIPE_CFG))
      st_next.pipe_type = wdata[1:0];
    if (wr_stb && (addr[11:0] == usbis_pkg::OFF_EP_MASK))
      st_next.ep_mask = wdata[usbis_pkg::ES_WIDTH-1:0];
    if (wr_stb && (addr[11:0] == usbis_pkg::OFF_EP_CFG))
    begin
      st_next.ep_type = wdata[1:0];
      st_next.ep_dir_out = wdata[2];
    end
    if (wr_stb && (addr[11:0] == usbis_pkg::OFF_GLB_MASK))
      st_next.gl_mask = wdata[usbis_pkg::GS_WIDTH-1:0];
    // Read-to-clear; a new event in the same cycle survives
    st_next.pipe_stat = (rd_stb && addr[11:0] == usbis_pkg::OFF_PIPE_STAT) ? pipe_event
      : (st_reg.pipe_stat | pipe_event);
    st_next.ep_stat = (rd_stb && addr[11:0] == usbis_pkg::OFF_EP_STAT) ? ep_set
      : (st_reg.ep_stat | ep_set);
    st_next.gl_stat = (rd_stb && addr[11:0] == usbis_pkg::OFF_GLB_STAT) ? gl_set
      : (st_reg.gl_stat | gl_set);
    st_next.bank_store = ep_set[usbis_pkg::ES_OUT_RX];
    st_next.pipe_request = pipe_request_want && !st_next.pipe_mask[usbis_pkg::PM_HALT];
    st_next.endpoint_irq = |(st_next.ep_stat & st_next.ep_mask);
    st_next.pipe_irq = |(st_next.pipe_stat & st_next.pipe_mask[7:0]);
    st_next.irq = |(st_next.gl_stat & st_next.gl_mask) || st_next.pipe_irq;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
      st_reg.pipe_mask <= usbis_pkg::PM_RESET;
    end
    else
      st_reg <= st_next;
  end

  assign rdata = st_reg.rdata;
  assign pipe_request = st_reg.pipe_request;
  assign data_toggle = st_reg.data_toggle;
  assign bank_store = st_reg.bank_store;
  assign endpoint_irq = st_reg.endpoint_irq;
  assign pipe_irq = st_reg.pipe_irq;
  assign irq = st_reg.irq;

  // ==========================================================================
  // Assertions
  sequence s_stall_seen;
    pipe_event[usbis_pkg::PE_STALL] || pipe_event[usbis_pkg::PE_PIPE_ERR];
  endsequence

  a_crc_iso_only: assert property (@(posedge clk) disable iff (!nrst)
    !iso_out |=> !(st_reg.ep_stat[usbis_pkg::ES_CRC_ERR] && !$past(st_reg.ep_stat[usbis_pkg::ES_CRC_ERR])))
    else $error("CRC flag set on a non-iso-OUT endpoint");
  a_crc_irq_gate: assert property (@(posedge clk) disable iff (!nrst)
    st_reg.ep_stat[usbis_pkg::ES_CRC_ERR] && !st_reg.ep_mask[usbis_pkg::ES_CRC_ERR]
    && ((st_reg.ep_stat & st_reg.ep_mask) == '0) |-> !endpoint_irq)
    else $error("CRC flag raised endpoint irq while disabled");
  a_crc_out_store: assert property (@(posedge clk) disable iff (!nrst)
    crc_error_seen && iso_out |=> bank_store && st_reg.ep_stat[usbis_pkg::ES_OUT_RX])
    else $error("Corrupted OUT packet not stored");
  a_frame_exc_class: assert property (@(posedge clk) disable iff (!nrst)
    global_event[usbis_pkg::GS_SOF] && frame_number_crc_error
    |=> st_reg.gl_stat[usbis_pkg::GS_FRAME_EXC])
    else $error("Frame CRC error not classed as exception");
  a_halt_blocks_req: assert property (@(posedge clk) disable iff (!nrst)
    st_reg.pipe_mask[usbis_pkg::PM_HALT] |-> !pipe_request)
    else $error("Request issued while pipe halted");
  a_halt_on_stall: assert property (@(posedge clk) disable iff (!nrst)
    s_stall_seen |=> st_reg.pipe_mask[usbis_pkg::PM_HALT] [*1] ##1 1'b1)
    else $error("Stall or error did not halt the pipe");
  a_toggle_reset: assert property (@(posedge clk) disable iff (!nrst)
    wr_set && wdata[usbis_pkg::PM_TOGGLE_RESET]
    |=> !data_toggle && st_reg.pipe_mask[usbis_pkg::PM_TOGGLE_RESET] ##1
    !st_reg.pipe_mask[usbis_pkg::PM_TOGGLE_RESET])
    else $error("Toggle reset not applied");
  a_pipe_irq_or: assert property (@(posedge clk) disable iff (!nrst)
    pipe_irq == |(st_reg.pipe_stat & st_reg.pipe_mask[7:0]))
    else $error("Pipe irq does not match flags and enables");
  a_type_gate: assert property (@(posedge clk) disable iff (!nrst)
    wr_stb && addr[11:0] == usbis_pkg::OFF_PIPE_SET && !ctl_bulk && pipe_configured
    && !pipe_event[usbis_pkg::PE_STALL] && !pipe_event[usbis_pkg::PE_PIPE_ERR]
    |=> st_reg.pipe_mask == $past(st_reg.pipe_mask)
    || $past(st_reg.pipe_mask[usbis_pkg::PM_TOGGLE_RESET]))
    else $error("Pipe mask changed for wrong pipe type");

  // ==========================================================================
  // Classification, flag and pipe checks
  // Sticky bits land one edge after the input pulse, so checks look there
  a_crc_sets_flag: assert property (@(posedge clk) disable iff (!nrst)
    crc_error_seen && iso_out |=> st_reg.ep_stat[usbis_pkg::ES_CRC_ERR])
    else $error("CRC error on iso OUT endpoint not flagged");

  a_out_store: assert property (@(posedge clk) disable iff (!nrst)
    endpoint_event[usbis_pkg::ES_OUT_RX]
    |=> bank_store && st_reg.ep_stat[usbis_pkg::ES_OUT_RX])
    else $error("Received OUT packet not stored");

  a_class_split: assert property (@(posedge clk) disable iff (!nrst)
    !(gl_set[usbis_pkg::GS_SOF] && gl_set[usbis_pkg::GS_FRAME_EXC])
    && !(gl_set[usbis_pkg::GS_MICRO_FRAME_START_FLAG] && gl_set[usbis_pkg::GS_FRAME_EXC]))
    else $error("Frame start placed in both classes");

  a_sof_clean: assert property (@(posedge clk) disable iff (!nrst)
    global_event[usbis_pkg::GS_SOF] && !frame_number_crc_error |=> st_reg.gl_stat[usbis_pkg::GS_SOF])
    else $error("Clean frame start not flagged");

  a_micro_frame_start_flag_clean: assert property (@(posedge clk) disable iff (!nrst)
    global_event[usbis_pkg::GS_MICRO_FRAME_START_FLAG] && !frame_number_crc_error
    |=> st_reg.gl_stat[usbis_pkg::GS_MICRO_FRAME_START_FLAG])
    else $error("Clean micro frame start not flagged");

  a_micro_frame_start_flag_exc: assert property (@(posedge clk) disable iff (!nrst)
    global_event[usbis_pkg::GS_MICRO_FRAME_START_FLAG] && frame_number_crc_error
    |=> st_reg.gl_stat[usbis_pkg::GS_FRAME_EXC])
    else $error("Micro frame CRC error not classed as exception");

  a_mdata_class: assert property (@(posedge clk) disable iff (!nrst)
    iso_out && endpoint_event[usbis_pkg::ES_OUT_RX] && data_sequence_field == usbis_pkg::DSEQ_MDATA
    |=> st_reg.ep_stat[usbis_pkg::ES_MDATA])
    else $error("Iso multiple-data OUT not flagged");

  a_datax_class: assert property (@(posedge clk) disable iff (!nrst)
    iso_out && endpoint_event[usbis_pkg::ES_OUT_RX] && data_sequence_field == usbis_pkg::DSEQ_DATAX
    |=> st_reg.ep_stat[usbis_pkg::ES_DATAX])
    else $error("Iso DATAX OUT not flagged");

  a_ep_exc_bits: assert property (@(posedge clk) disable iff (!nrst)
    (endpoint_event & 12'h0780) != 12'h000 |=> (st_reg.ep_stat & 12'h0780) != 12'h000)
    else $error("Endpoint exception event not flagged");

  a_set_halt: assert property (@(posedge clk) disable iff (!nrst)
    wr_set && wdata[usbis_pkg::PM_HALT] |=> st_reg.pipe_mask[usbis_pkg::PM_HALT])
    else $error("Software halt set ignored");

  a_unconf_halt: assert property (@(posedge clk) disable iff (!nrst)
    !pipe_configured |=> st_reg.pipe_mask[usbis_pkg::PM_HALT])
    else $error("Unconfigured pipe not halted");

  a_halt_clear: assert property (@(posedge clk) disable iff (!nrst)
    wr_clr && wdata[usbis_pkg::PM_HALT] && pipe_configured && !s_stall_seen
    |=> !st_reg.pipe_mask[usbis_pkg::PM_HALT])
    else $error("Halt clear did not release the pipe");

  a_req_follows: assert property (@(posedge clk) disable iff (!nrst)
    pipe_request_want && !st_next.pipe_mask[usbis_pkg::PM_HALT] |=> pipe_request)
    else $error("Request missing on a running pipe");

  a_mask_layout: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.pipe_mask & ~set_clr_mask) == 32'h0000_0000)
    else $error("Pipe mask holds a bit outside its layout");

  a_ep_irq_or: assert property (@(posedge clk) disable iff (!nrst)
    endpoint_irq == |(st_reg.ep_stat & st_reg.ep_mask))
    else $error("Endpoint irq does not match flags and enables");

  a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
    irq == (|(st_reg.gl_stat & st_reg.gl_mask) || pipe_irq))
    else $error("Irq does not match global flags and pipe irq");
endmodule : usbis_core

// *** pkg/usbis_pkg.sv ***
// Package with register map, field positions and reset values of the USB interrupt/status block
package usbis_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_PIPE_MASK = 12'h05c0;
  localparam logic [11:0] OFF_PIPE_SET = 12'h0600;
  localparam logic [11:0] OFF_PIPE_CLR = 12'h0640;
  localparam logic [11:0] OFF_PIPE_STAT = 12'h0680;
  localparam logic [11:0] OFF_PIPE_CFG = 12'h06c0;
  localparam logic [11:0] OFF_EP_STAT = 12'h0100;
  localparam logic [11:0] OFF_EP_MASK = 12'h0140;
  localparam logic [11:0] OFF_EP_CFG = 12'h0180;
  localparam logic [11:0] OFF_GLB_STAT = 12'h0200;
  localparam logic [11:0] OFF_GLB_MASK = 12'h0240;
  localparam logic [11:0] OFF_GLB_CLASS = 12'h0280;
  // ==========================================================================
  // Pipe mask fields
  localparam int PM_TOGGLE_RESET = 18;
  localparam int PM_HALT = 17;
  localparam int PM_DMA_DIS = 16;
  localparam int PM_FIFO_CTRL = 14;
  localparam int PM_BUSY_EN = 12;
  localparam logic [31:0] PM_WMASK = 32'h0005_50ff;
  localparam logic [31:0] PM_RESET = 32'h0000_0000;
  // Pipe event bits 7:0: in_rx, out_tx, setup_tx, pipe_err, naked, overflow, stall, short
  localparam int PE_PIPE_ERR = 3;
  localparam int PE_STALL = 6;
  localparam logic [1:0] PT_CONTROL = 2'h0;
  localparam logic [1:0] PT_BULK = 2'h2;
  // ==========================================================================
  // Endpoint status bits
  localparam int ES_IN_SENT = 0;
  localparam int ES_OUT_RX = 1;
  localparam int ES_SETUP_RX = 2;
  localparam int ES_SHORT = 3;
  localparam int ES_BUSY = 4;
  localparam int ES_MDATA = 5;
  localparam int ES_DATAX = 6;
  localparam int ES_UNDERFLOW = 7;
  localparam int ES_OUT_NAK = 8;
  localparam int ES_HB_ISO_ERR = 9;
  localparam int ES_IN_NAK = 10;
  localparam int ES_CRC_ERR = 11;
  localparam int ES_WIDTH = 12;
  localparam logic [11:0] ES_EXCEPTION = 12'h0f80;
  localparam logic [1:0] EP_TYPE_ISO = 2'h1;
  localparam logic [1:0] DSEQ_DATAX = 2'h1;
  localparam logic [1:0] DSEQ_MDATA = 2'h3;
  // ==========================================================================
  // Global status bits
  localparam int GS_SUSPEND = 0;
  localparam int GS_SOF = 1;
  localparam int GS_MICRO_FRAME_START_FLAG = 2;
  localparam int GS_RESET_DONE = 3;
  localparam int GS_WAKEUP = 4;
  localparam int GS_RESUME_DONE = 5;
  localparam int GS_UP_RESUME = 6;
  localparam int GS_ENDPOINT = 7;
  localparam int GS_DMA = 8;
  localparam int GS_FRAME_EXC = 9;
  localparam int GS_WIDTH = 10;
endpackage : usbis_pkg

// *** sim/testbench.sv ***
// Self-checking bench for the interrupt and status block
`timescale 1ns/1ps
module testbench;
  logic clk, nrst, wr_stb, rd_stb, cfg_ok, want, fe, cs, bank_seen;
  logic [11:0] addr, e;
  logic [31:0] wdata, rdata, d;
  logic [9:0] g;
  logic [1:0] sq;
  logic [7:0] p;
  logic pipe_request, data_toggle, bank_store, endpoint_irq, pipe_irq, irq;
  int mismatches, cmp_count, i;
  usbis_far_model far (.clk(clk), .glb_ev(g), .fnc_err(fe), .ep_ev(e), .crc_seen(cs),
    .dseq(sq), .pipe_ev(p));
  usbis_core dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .global_event(g), .frame_number_crc_error(fe),
    .endpoint_event(e), .crc_error_seen(cs), .data_sequence_field(sq), .pipe_event(p),
    .pipe_configured(cfg_ok), .pipe_request_want(want), .pipe_request(pipe_request),
    .data_toggle(data_toggle), .bank_store(bank_store), .endpoint_irq(endpoint_irq),
    .pipe_irq(pipe_irq), .irq(irq));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Store pulses are one cycle long, so they are latched for a later look
  always @(posedge clk)
    if (bank_store === 1'b1) bank_seen <= 1'b1;
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task cmp32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t read %h expected %h", $time, got, exp);
    end
  endtask : cmp32
  task cmp1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp1
  task chk_rd(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    cmp32(d, exp);
  endtask : chk_rd
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  initial
  begin
    #1000000;
    mismatches++;
    $display("MISMATCH %0t run did not finish", $time);
    conclude();
  end
  initial
  begin
    nrst = 1'b0; wr_stb = 1'b0; rd_stb = 1'b0; addr = '0; wdata = '0;
    cfg_ok = 1'b1; want = 1'b0; bank_seen = 1'b0; mismatches = 0; cmp_count = 0;
    idle(2);
    nrst <= 1'b1;
    chk_rd(usbis_pkg::OFF_PIPE_MASK, 32'h0000_0000);
    chk_rd(12'h07fc, 32'h0000_0000);
    wr(usbis_pkg::OFF_PIPE_MASK, 32'hfffb_ffff);
    chk_rd(usbis_pkg::OFF_PIPE_MASK, 32'h0001_50ff);
    wr(usbis_pkg::OFF_PIPE_CFG, 32'h0000_0001);
    wr(usbis_pkg::OFF_PIPE_MASK, 32'h0000_0000);
    wr(usbis_pkg::OFF_PIPE_SET, 32'h0000_00ff);
    chk_rd(usbis_pkg::OFF_PIPE_MASK, 32'h0001_50ff);
    wr(usbis_pkg::OFF_PIPE_CFG, 32'h0000_0002);
    wr(usbis_pkg::OFF_PIPE_MASK, 32'h0000_0040);
    chk_rd(usbis_pkg::OFF_PIPE_MASK, 32'h0000_0040);
    wr(usbis_pkg::OFF_PIPE_CFG, 32'h0000_0000);
    $display("test done: pipe mask map");
    // ========================================================================
    // Halt sources and clear
    want <= 1'b1;
    idle(3);
    cmp1(pipe_request, 1'b1);
    wr(usbis_pkg::OFF_PIPE_SET, 32'h0002_0000);
    idle(2);
    cmp1(pipe_request, 1'b0);
    chk_rd(usbis_pkg::OFF_PIPE_MASK, 32'h0002_0040);
    wr(usbis_pkg::OFF_PIPE_CLR, 32'h0002_0000);
    idle(2);
    cmp1(pipe_request, 1'b1);
    far.ev('0, 1'b0, '0, 1'b0, 2'h0, 8'h40);
    idle(2);
    cmp1(pipe_request, 1'b0);
    cmp1(pipe_irq, 1'b1);
    chk_rd(usbis_pkg::OFF_PIPE_STAT, 32'h0000_0040);
    idle(1);
    cmp1(pipe_irq, 1'b0);
    wr(usbis_pkg::OFF_PIPE_CLR, 32'h0002_0000);
    far.ev('0, 1'b0, '0, 1'b0, 2'h0, 8'h08);
    idle(2);
    cmp1(pipe_request, 1'b0);
    cmp1(pipe_irq, 1'b0);
    rd(usbis_pkg::OFF_PIPE_STAT);
    wr(usbis_pkg::OFF_PIPE_CLR, 32'h0002_0000);
    cfg_ok <= 1'b0;
    idle(2);
    cmp1(pipe_request, 1'b0);
    cfg_ok <= 1'b1;
    wr(usbis_pkg::OFF_PIPE_CLR, 32'h0002_0000);
    idle(2);
    cmp1(pipe_request, 1'b1);
    wr(usbis_pkg::OFF_PIPE_SET, 32'h0002_0000);
    wr(usbis_pkg::OFF_PIPE_SET, 32'h0004_0000);
    idle(1);
    cmp1(data_toggle, 1'b0);
    $display("test done: pipe halt and toggle");
    // ========================================================================
    // Endpoint CRC handling and classes
    far.ev('0, 1'b0, 12'h002, 1'b1, 2'h0, 8'h00);
    idle(2);
    cmp1(bank_seen, 1'b1);
    chk_rd(usbis_pkg::OFF_EP_STAT, 32'h0000_0002);
    bank_seen <= 1'b0;
    wr(usbis_pkg::OFF_EP_CFG, 32'h0000_0005);
    far.ev('0, 1'b0, 12'h002, 1'b1, usbis_pkg::DSEQ_MDATA, 8'h00);
    idle(2);
    cmp1(bank_seen, 1'b1);
    cmp1(endpoint_irq, 1'b0);
    chk_rd(usbis_pkg::OFF_EP_STAT, 32'h0000_0822);
    wr(usbis_pkg::OFF_EP_MASK, 32'h0000_0800);
    far.ev('0, 1'b0, 12'h002, 1'b1, usbis_pkg::DSEQ_DATAX, 8'h00);
    idle(2);
    cmp1(endpoint_irq, 1'b1);
    chk_rd(usbis_pkg::OFF_EP_STAT, 32'h0000_0842);
    idle(1);
    cmp1(endpoint_irq, 1'b0);
    far.ev('0, 1'b0, 12'h79d, 1'b0, 2'h0, 8'h00);
    idle(1);
    chk_rd(usbis_pkg::OFF_EP_STAT, 32'h0000_079d);
    chk_rd(usbis_pkg::OFF_GLB_CLASS, 32'h0200_0f80);
    rd(usbis_pkg::OFF_GLB_STAT);
    $display("test done: endpoint events");
    // ========================================================================
    // Global events, frame-start exception and interrupt output
    for (i = 0; i < 9; i++)
    begin
      far.ev(10'h001 << i, 1'b0, '0, 1'b0, 2'h0, 8'h00);
      idle(1);
      chk_rd(usbis_pkg::OFF_GLB_STAT, 32'h0000_0001 << i);
    end
    far.ev(10'h002, 1'b1, '0, 1'b0, 2'h0, 8'h00);
    idle(1);
    rd(usbis_pkg::OFF_GLB_STAT);
    cmp1(d[usbis_pkg::GS_FRAME_EXC], 1'b1);
    wr(usbis_pkg::OFF_GLB_MASK, 32'h0000_0200);
    far.ev(10'h004, 1'b1, '0, 1'b0, 2'h0, 8'h00);
    idle(2);
    cmp1(irq, 1'b1);
    rd(usbis_pkg::OFF_GLB_STAT);
    idle(1);
    cmp1(irq, 1'b0);
    $display("test done: global events");
    conclude();
  end
endmodule : testbench

// *** sim/usbis_far_model.sv ***
// Behavioural model of the USB bus side, producing event pulses
`timescale 1ns/1ps
module usbis_far_model (
  input wire logic clk,
  output logic [usbis_pkg::GS_WIDTH-1:0] glb_ev,
  output logic fnc_err,
  output logic [usbis_pkg::ES_WIDTH-1:0] ep_ev,
  output logic crc_seen,
  output logic [1:0] dseq,
  output logic [7:0] pipe_ev
);
  initial
  begin
    glb_ev = '0;
    fnc_err = 1'b0;
    ep_ev = '0;
    crc_seen = 1'b0;
    dseq = 2'h0;
    pipe_ev = 8'h00;
  end
  // ==========================================================================
  // One-cycle pulse of every qualifier but dseq, which then takes its complement, as the bus delivers them
  task ev(input logic [9:0] g, input logic f, input logic [11:0] e, input logic c,
          input logic [1:0] s, input logic [7:0] p);
    @(posedge clk);
    glb_ev <= g;
    fnc_err <= f;
    ep_ev <= e;
    crc_seen <= c;
    dseq <= s;
    pipe_ev <= p;
    @(posedge clk);
    glb_ev <= '0;
    fnc_err <= 1'b0;
    ep_ev <= '0;
    crc_seen <= 1'b0;
    dseq <= ~s;
    pipe_ev <= 8'h00;
  endtask : ev
endmodule : usbis_far_model
